// ### rtl/zbpu_top.v
// Operation
// - Default EBCDIC pack keeps low nibble as digit, no validity check.
// - Default EBCDIC pack takes sign from upper nibble of rightmost source byte.
// - Pack writes preferred sign: ASCII A/B, EBCDIC C/D.
// - Unknown source sign in pack may leave low result nibble any value.
// - Separate-sign pack treats rightmost source byte as a sign character.
// - Separate-sign pack strips zones, writes preferred sign code.
// - Both bits set: pack always writes preferred positive sign.
// - Unpack turns packed source into zoned result, right to left.
// - Short unpack source fills high result bytes with zone and zero.
// - Long unpack source drops excess high-order digits.
// - Unpack zones, sign characters, preferred signs follow charset.
// - ASCII default unpack writes overpunched sign and low-order digit.
// - Unknown sign in ASCII unpack may give any rightmost byte.
// - EBCDIC default unpack places preferred sign with low-order digit.
// - Separate-sign unpack writes sign character into rightmost byte.
// - Both bits set unpack writes sign character, flags fault if negative.
// - Six sign codes recognised; 1011 and 1101 negative, digits 0..9.
// - ASCII default pack decodes overpunched rightmost byte.
// - Short pack source pads zeros; long source drops high digits.
`include "zbpu_regs.vh"

module zbpu_top #(
    parameter LEN_W = `ZBPU_LEN_W
) (
    // Clock and reset
    input  wire             REF_CLK_I,
    input  wire             SYS_RST_I,
    // Operation request
    input  wire             START_I,
    input  wire             OP_UNPACK_I,
    input  wire [1:0]       SIGN_CTRL_I,
    input  wire             CHARSET_EBCDIC_I,
    input  wire [LEN_W-1:0] SRC_LEN_I,
    input  wire [LEN_W-1:0] RES_LEN_I,
    // Source field read
    output wire             SRC_RD_O,
    output wire [LEN_W-1:0] SRC_IDX_O,
    input  wire [7:0]       SRC_DATA_I,
    // Result field write
    output wire             RES_WR_O,
    output wire [LEN_W-1:0] RES_IDX_O,
    output wire [7:0]       RES_DATA_O,
    // Status
    output wire             BUSY_O,
    output wire             DONE_O,
    output wire             DEC_FAULT_O
);

    localparam [1:0] S_IDLE = 2'h0;
    localparam [1:0] S_HEAD = 2'h1;
    localparam [1:0] S_GET  = 2'h2;
    localparam [1:0] S_USE  = 2'h3;

    reg [1:0]       state_q;
    reg             unpack_q;
    reg [1:0]       mode_q;
    reg             ebcdic_q;
    reg             head_src_q;
    reg [LEN_W-1:0] src_left_q;
    reg [LEN_W-1:0] src_idx_q;
    reg [LEN_W-1:0] res_left_q;
    reg [LEN_W-1:0] res_idx_q;
    reg             hold_vld_q;
    reg [3:0]       hold_q;
    reg             nib_hi_q;
    reg [3:0]       acc_q;
    reg             fault_q;
    reg             rd_q;
    reg             wr_q;
    reg [7:0]       wdata_q;
    reg             busy_q;
    reg             done_q;
    reg             fault_out_q;

    wire [7:0] head_byte;
    wire [3:0] pk_sign;
    wire [3:0] pk_lsd;
    wire       pk_lsd_vld;
    wire [7:0] up_byte0;
    wire       up_neg;
    wire       up_lsd_used;
    wire [3:0] zone;

    reg        emit;
    reg  [3:0] digit;

    // A zero-length source acts as a positive zero.
    assign head_byte = head_src_q ? SRC_DATA_I : 8'h00;

    zbpu_sign_xlat u_xlat (
        .mode_i        (mode_q),
        .ebcdic_i      (ebcdic_q),
        .byte_i        (head_byte),
        .pk_sign_o     (pk_sign),
        .pk_lsd_o      (pk_lsd),
        .pk_lsd_vld_o  (pk_lsd_vld),
        .up_byte0_o    (up_byte0),
        .up_neg_o      (up_neg),
        .up_lsd_used_o (up_lsd_used),
        .zone_o        (zone)
    );

    // Digit supply: a held digit first, then source bytes, then zeros.
    always @*
    begin
        emit  = 1'b0;
        digit = 4'h0;
        if (state_q == S_USE)
        begin
            emit  = 1'b1;
            digit = SRC_DATA_I[3:0];
        end
        else if (state_q == S_GET && res_left_q != {LEN_W{1'b0}})
        begin
            if (hold_vld_q)
            begin
                emit  = 1'b1;
                digit = hold_q;
            end
            else if (src_left_q == {LEN_W{1'b0}})
            begin
                emit  = 1'b1;
                digit = 4'h0;
            end
        end
    end

    always @(posedge REF_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            state_q     <= S_IDLE;
            unpack_q    <= 1'b0;
            mode_q      <= 2'h0;
            ebcdic_q    <= 1'b0;
            head_src_q  <= 1'b0;
            src_left_q  <= {LEN_W{1'b0}};
            src_idx_q   <= {LEN_W{1'b0}};
            res_left_q  <= {LEN_W{1'b0}};
            res_idx_q   <= {LEN_W{1'b0}};
            hold_vld_q  <= 1'b0;
            hold_q      <= 4'h0;
            nib_hi_q    <= 1'b0;
            acc_q       <= 4'h0;
            fault_q     <= 1'b0;
            rd_q        <= 1'b0;
            wr_q        <= 1'b0;
            wdata_q     <= 8'h00;
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
            fault_out_q <= 1'b0;
        end
        else
        begin
            rd_q        <= 1'b0;
            wr_q        <= 1'b0;
            done_q      <= 1'b0;
            fault_out_q <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (START_I)
                    begin
                        unpack_q   <= OP_UNPACK_I;
                        mode_q     <= SIGN_CTRL_I;
                        ebcdic_q   <= CHARSET_EBCDIC_I;
                        head_src_q <= (SRC_LEN_I != {LEN_W{1'b0}});
                        res_left_q <= RES_LEN_I;
                        res_idx_q  <= RES_LEN_I - 1'b1;
                        src_idx_q  <= SRC_LEN_I - 1'b1;
                        fault_q    <= 1'b0;
                        hold_vld_q <= 1'b0;
                        if (RES_LEN_I == {LEN_W{1'b0}})
                            done_q <= 1'b1;
                        else
                        begin
                            busy_q  <= 1'b1;
                            rd_q    <= (SRC_LEN_I != {LEN_W{1'b0}});
                            state_q <= S_HEAD;
                        end
                    end
                end
                S_HEAD:
                begin
                    src_idx_q  <= src_idx_q - 1'b1;
                    src_left_q <= head_src_q ? src_idx_q : {LEN_W{1'b0}};
                    state_q    <= S_GET;
                    if (!unpack_q)
                    begin
                        // Sign goes to the low nibble of the rightmost byte.
                        acc_q      <= pk_sign;
                        nib_hi_q   <= 1'b1;
                        hold_q     <= pk_lsd;
                        hold_vld_q <= pk_lsd_vld;
                    end
                    else
                    begin
                        // Rightmost result byte carries the sign.
                        wr_q       <= 1'b1;
                        wdata_q    <= up_byte0;
                        hold_q     <= head_byte[7:4];
                        hold_vld_q <= ~up_lsd_used;
                        fault_q    <= (mode_q == `ZBPU_MODE_FORCEPOS) &&
                                      up_neg;
                        res_left_q <= res_left_q - 1'b1;
                    end
                end
                S_GET:
                begin
                    if (res_left_q == {LEN_W{1'b0}})
                    begin
                        // Excess source bytes are never read.
                        busy_q      <= 1'b0;
                        done_q      <= 1'b1;
                        fault_out_q <= fault_q;
                        state_q     <= S_IDLE;
                    end
                    else if (hold_vld_q)
                        hold_vld_q <= 1'b0;
                    else if (src_left_q != {LEN_W{1'b0}})
                    begin
                        rd_q       <= 1'b1;
                        src_left_q <= src_left_q - 1'b1;
                        state_q    <= S_USE;
                    end
                end
                S_USE:
                begin
                    src_idx_q <= src_idx_q - 1'b1;
                    state_q   <= S_GET;
                    if (unpack_q)
                    begin
                        // High nibble of a packed byte is the next digit.
                        hold_q     <= SRC_DATA_I[7:4];
                        hold_vld_q <= 1'b1;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase

            if (emit)
            begin
                if (unpack_q)
                begin
                    wr_q       <= 1'b1;
                    wdata_q    <= {zone, digit};
                    res_left_q <= res_left_q - 1'b1;
                end
                else if (nib_hi_q)
                begin
                    wr_q       <= 1'b1;
                    wdata_q    <= {digit, acc_q};
                    res_left_q <= res_left_q - 1'b1;
                    nib_hi_q   <= 1'b0;
                end
                else
                begin
                    acc_q    <= digit;
                    nib_hi_q <= 1'b1;
                end
            end

            // Result index steps left after each byte leaves.
            if (wr_q)
                res_idx_q <= res_idx_q - 1'b1;
        end
    end

    assign SRC_RD_O    = rd_q;
    assign SRC_IDX_O   = src_idx_q;
    assign RES_WR_O    = wr_q;
    assign RES_IDX_O   = res_idx_q;
    assign RES_DATA_O  = wdata_q;
    assign BUSY_O      = busy_q;
    assign DONE_O      = done_q;
    assign DEC_FAULT_O = fault_out_q;

endmodule

// ### rtl/zbpu_regs.vh
`ifndef ZBPU_REGS_VH
`define ZBPU_REGS_VH

// Sign control field values (bit 0 is the low bit).
`define ZBPU_MODE_DEFAULT    2'h0
`define ZBPU_MODE_SEPSIGN    2'h1
`define ZBPU_MODE_UNDEF      2'h2
`define ZBPU_MODE_FORCEPOS   2'h3

// Field length width in bits.
`define ZBPU_LEN_W           8

// Packed sign codes that read as negative; all others of 1010..1111 are +.
`define ZBPU_SIGN_NEG_A      4'hb
`define ZBPU_SIGN_NEG_B      4'hd

// Preferred sign codes.
`define ZBPU_PREF_POS_ASCII  4'ha
`define ZBPU_PREF_NEG_ASCII  4'hb
`define ZBPU_PREF_POS_EBCDIC 4'hc
`define ZBPU_PREF_NEG_EBCDIC 4'hd

// Zone nibbles.
`define ZBPU_ZONE_ASCII      4'h3
`define ZBPU_ZONE_EBCDIC     4'hf

// Separate sign characters.
`define ZBPU_SCHR_POS_ASCII  8'h2b
`define ZBPU_SCHR_NEG_ASCII  8'h2d
`define ZBPU_SCHR_POS_EBCDIC 8'h4e
`define ZBPU_SCHR_NEG_EBCDIC 8'h60

// Overpunched character ranges and bases.
`define ZBPU_DIG_LO          8'h30
`define ZBPU_DIG_HI          8'h39
`define ZBPU_OP_POS_ZERO     8'h7b
`define ZBPU_OP_NEG_ZERO     8'h7d
`define ZBPU_OP_POS_LO       8'h41
`define ZBPU_OP_POS_HI       8'h49
`define ZBPU_OP_NEG_LO       8'h4a
`define ZBPU_OP_NEG_HI       8'h52
`define ZBPU_OP_POS_BASE     8'h40
`define ZBPU_OP_NEG_BASE     8'h49

`endif

// ### rtl/zbpu_sign_xlat.v
`include "zbpu_regs.vh"

module zbpu_sign_xlat (
    // Selection
    input  wire [1:0] mode_i,
    input  wire       ebcdic_i,
    // Rightmost source byte
    input  wire [7:0] byte_i,
    // Pack view
    output reg  [3:0] pk_sign_o,
    output reg  [3:0] pk_lsd_o,
    output reg        pk_lsd_vld_o,
    // Unpack view
    output reg  [7:0] up_byte0_o,
    output reg        up_neg_o,
    output reg        up_lsd_used_o,
    output wire [3:0] zone_o
);

    reg       pk_neg;
    reg [7:0] op_diff;

    function is_neg;
        input [3:0] nib;
        begin
            is_neg = (nib == `ZBPU_SIGN_NEG_A) || (nib == `ZBPU_SIGN_NEG_B);
        end
    endfunction

    function [3:0] pref_sign;
        input neg;
        input ebc;
        begin
            if (ebc)
                pref_sign = neg ? `ZBPU_PREF_NEG_EBCDIC : `ZBPU_PREF_POS_EBCDIC;
            else
                pref_sign = neg ? `ZBPU_PREF_NEG_ASCII : `ZBPU_PREF_POS_ASCII;
        end
    endfunction

    function [7:0] sign_char;
        input neg;
        input ebc;
        begin
            if (ebc)
                sign_char = neg ? `ZBPU_SCHR_NEG_EBCDIC : `ZBPU_SCHR_POS_EBCDIC;
            else
                sign_char = neg ? `ZBPU_SCHR_NEG_ASCII : `ZBPU_SCHR_POS_ASCII;
        end
    endfunction

    assign zone_o = ebcdic_i ? `ZBPU_ZONE_EBCDIC : `ZBPU_ZONE_ASCII;

    always @*
    begin
        pk_neg       = 1'b0;
        pk_lsd_o     = byte_i[3:0];
        pk_lsd_vld_o = 1'b1;
        op_diff      = byte_i - `ZBPU_OP_NEG_BASE;
        case (mode_i)
            `ZBPU_MODE_SEPSIGN:
            begin
                pk_neg       = (byte_i == sign_char(1'b1, ebcdic_i));
                pk_lsd_vld_o = 1'b0;
            end
            `ZBPU_MODE_FORCEPOS:
            begin
                pk_neg = 1'b0;
            end
            default:
            begin
                if (ebcdic_i)
                    pk_neg = is_neg(byte_i[7:4]);
                else if (byte_i == `ZBPU_OP_POS_ZERO)
                    pk_lsd_o = 4'h0;
                else if (byte_i == `ZBPU_OP_NEG_ZERO)
                begin
                    pk_neg   = 1'b1;
                    pk_lsd_o = 4'h0;
                end
                else if (byte_i >= `ZBPU_OP_NEG_LO &&
                         byte_i <= `ZBPU_OP_NEG_HI)
                begin
                    pk_neg   = 1'b1;
                    pk_lsd_o = op_diff[3:0];
                end
            end
        endcase
        pk_sign_o = pref_sign(pk_neg, ebcdic_i);
    end

    always @*
    begin
        up_neg_o      = is_neg(byte_i[3:0]);
        up_lsd_used_o = ~mode_i[0];
        if (mode_i[0])
            up_byte0_o = sign_char(up_neg_o, ebcdic_i);
        else if (ebcdic_i)
            up_byte0_o = {pref_sign(up_neg_o, 1'b1), byte_i[7:4]};
        else if (byte_i[7:4] == 4'h0)
            up_byte0_o = up_neg_o ? `ZBPU_OP_NEG_ZERO : `ZBPU_OP_POS_ZERO;
        else if (up_neg_o)
            up_byte0_o = `ZBPU_OP_NEG_BASE + {4'h0, byte_i[7:4]};
        else
            up_byte0_o = `ZBPU_OP_POS_BASE + {4'h0, byte_i[7:4]};
    end

endmodule

// ### testbench/zbpu_top_properties.sv
module zbpu_top_chk #(
    parameter LEN_W = 8
) (
    input wire logic             REF_CLK_I,
    input wire logic             SYS_RST_I,
    input wire logic             START_I,
    input wire logic             OP_UNPACK_I,
    input wire logic [1:0]       SIGN_CTRL_I,
    input wire logic             CHARSET_EBCDIC_I,
    input wire logic [LEN_W-1:0] SRC_LEN_I,
    input wire logic [LEN_W-1:0] RES_LEN_I,
    input wire logic             SRC_RD_O,
    input wire logic [LEN_W-1:0] SRC_IDX_O,
    input wire logic [7:0]       SRC_DATA_I,
    input wire logic             RES_WR_O,
    input wire logic [LEN_W-1:0] RES_IDX_O,
    input wire logic [7:0]       RES_DATA_O,
    input wire logic             BUSY_O,
    input wire logic             DONE_O,
    input wire logic             DEC_FAULT_O
);
    timeunit 1ns;
    timeprecision 1ns;
    logic             op_q;
    logic             ebc_q;
    logic [1:0]       mode_q;
    logic [LEN_W-1:0] sl_q;
    logic [LEN_W-1:0] rl_q;
    logic [LEN_W-1:0] rd_n_q;
    logic [LEN_W-1:0] wr_n_q;
    logic             take;

    assign take = START_I && !BUSY_O && !DONE_O;

    // Counts reads and writes since the request was taken.
    always @(posedge REF_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            op_q   <= 1'b0;
            ebc_q  <= 1'b0;
            mode_q <= 2'h0;
            sl_q   <= '0;
            rl_q   <= '0;
            rd_n_q <= '0;
            wr_n_q <= '0;
        end
        else if (take)
        begin
            op_q   <= OP_UNPACK_I;
            ebc_q  <= CHARSET_EBCDIC_I;
            mode_q <= SIGN_CTRL_I;
            sl_q   <= SRC_LEN_I;
            rl_q   <= RES_LEN_I;
            rd_n_q <= '0;
            wr_n_q <= '0;
        end
        else
        begin
            rd_n_q <= rd_n_q + {{(LEN_W-1){1'b0}}, SRC_RD_O};
            wr_n_q <= wr_n_q + {{(LEN_W-1){1'b0}}, RES_WR_O};
        end
    end

    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);

    sequence s_take;
        take && RES_LEN_I != '0;
    endsequence
    sequence s_run;
        BUSY_O ##[1:1000] DONE_O;
    endsequence

    property p_run;
        s_take |=> s_run;
    endproperty
    property p_empty;
        take && RES_LEN_I == '0 |=> !RES_WR_O throughout (##[0:1] DONE_O);
    endproperty
    property p_done_pulse;
        DONE_O |=> !DONE_O;
    endproperty
    property p_fault;
        DEC_FAULT_O |-> DONE_O && op_q && mode_q == 2'h3;
    endproperty
    property p_rd;
        SRC_RD_O |-> rd_n_q < sl_q && SRC_IDX_O == sl_q - rd_n_q - 1'b1;
    endproperty
    property p_wr;
        RES_WR_O |-> wr_n_q < rl_q && RES_IDX_O == rl_q - wr_n_q - 1'b1;
    endproperty
    property p_wr_count;
        DONE_O |-> wr_n_q == rl_q;
    endproperty
    property p_zone;
        RES_WR_O && op_q && wr_n_q != '0
            |-> RES_DATA_O[7:4] == (ebc_q ? 4'hf : 4'h3);
    endproperty
    property p_force_pos;
        RES_WR_O && !op_q && mode_q == 2'h3 && wr_n_q == '0
            |-> RES_DATA_O[3:0] == (ebc_q ? 4'hc : 4'ha);
    endproperty

    a_run: assert property (p_run) else $error("no completion");
    a_empty: assert property (p_empty) else $error("empty op");
    a_done_pulse: assert property (p_done_pulse) else $error("done");
    a_fault: assert property (p_fault) else $error("fault cause");
    a_rd: assert property (p_rd) else $error("read order");
    a_wr: assert property (p_wr) else $error("write order");
    a_wr_count: assert property (p_wr_count) else $error("count");
    a_zone: assert property (p_zone) else $error("zone");
    a_force_pos: assert property (p_force_pos) else $error("sign");
endmodule

bind zbpu_top zbpu_top_chk #(.LEN_W(LEN_W)) u_chk (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .START_I(START_I),
    .OP_UNPACK_I(OP_UNPACK_I), .SIGN_CTRL_I(SIGN_CTRL_I),
    .CHARSET_EBCDIC_I(CHARSET_EBCDIC_I), .SRC_LEN_I(SRC_LEN_I),
    .RES_LEN_I(RES_LEN_I), .SRC_RD_O(SRC_RD_O), .SRC_IDX_O(SRC_IDX_O),
    .SRC_DATA_I(SRC_DATA_I), .RES_WR_O(RES_WR_O), .RES_IDX_O(RES_IDX_O),
    .RES_DATA_O(RES_DATA_O), .BUSY_O(BUSY_O), .DONE_O(DONE_O),
    .DEC_FAULT_O(DEC_FAULT_O));

// ### testbench/zbpu_src_mem.sv
module zbpu_src_mem (
    input  wire logic       clk_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] idx_i,
    input  wire logic [7:0] img_i [0:7],
    output logic      [7:0] data_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] last_q = 8'h00;

    // Outside a read the field shows a pattern that changes every cycle.
    always_comb data_o = rd_i ? img_i[idx_i[2:0]] : ~last_q;
    always @(posedge clk_i) last_q <= data_o;
endmodule

// ### testbench/tb_zoned_bcd_pack_unpack_unit.sv
module tb_zoned_bcd_pack_unpack_unit;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic        op = 1'b0;
    logic [1:0]  mode = 2'h0;
    logic        ebc = 1'b0;
    logic [7:0]  sl = 8'h00;
    logic [7:0]  rl = 8'h00;
    wire         rd, wr, busy, done, fault;
    wire  [7:0]  sidx, ridx, rdata, sdata;
    logic [15:0] wq[$];
    logic        fq[$];
    logic [7:0]  src [0:7];
    logic [3:0]  dig [0:31];
    integer      errors = 0;
    integer      n_tests = 0;
    integer      seed = 32'h5f7a150c;
    int          i, m;

    always #25 clk = ~clk;

    zbpu_top dut (.REF_CLK_I(clk), .SYS_RST_I(rst), .START_I(start),
        .OP_UNPACK_I(op), .SIGN_CTRL_I(mode), .CHARSET_EBCDIC_I(ebc),
        .SRC_LEN_I(sl), .RES_LEN_I(rl), .SRC_RD_O(rd), .SRC_IDX_O(sidx),
        .SRC_DATA_I(sdata), .RES_WR_O(wr), .RES_IDX_O(ridx),
        .RES_DATA_O(rdata), .BUSY_O(busy), .DONE_O(done),
        .DEC_FAULT_O(fault));
    zbpu_src_mem mem_u (.clk_i(clk), .rd_i(rd), .idx_i(sidx),
        .img_i(src), .data_o(sdata));

    task check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task end_sim;
        $display("errors %0d of %0d compares", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    function automatic logic [7:0] opch(input logic n, input logic [3:0] d);
        opch = (d == 4'h0) ? (n ? 8'h7d : 8'h7b) : (n ? 8'h49 : 8'h40) + d;
    endfunction

    function automatic logic [7:0] sgch(input logic e, input logic n);
        sgch = e ? (n ? 8'h60 : 8'h4e) : (n ? 8'h2d : 8'h2b);
    endfunction

    always @(posedge clk)
    begin
        if (!rst && wr)
            check({ridx, rdata}, wq.pop_front());
        if (!rst && done)
            check({15'h0, fault}, {15'h0, fq.pop_front()});
    end

    task automatic run(input logic o, input logic [1:0] md, input logic e,
                       input int s, input int r);
        int j, k, d, c;
        logic n;
        logic [7:0] b;
        logic [3:0] z, ps;
        z = e ? 4'hf : 4'h3;
        n = 1'b0;
        k = 0;
        for (j = 0; j < 32; j++) dig[j] = 4'h0;
        for (j = s - 1; j >= 0; j--)
        begin
            d = {$random(seed)} % 10;
            c = {$random(seed)} % 10;
            src[j] = o ? {d[3:0], c[3:0]} : {z, d[3:0]};
            if (o && j == s - 1)
            begin
                c = {$random(seed)} % 6;
                src[j][3:0] = 4'ha + c[3:0];
                n = (c == 1) || (c == 3);
                dig[k++] = d[3:0];
            end
            else if (o)
            begin
                dig[k++] = c[3:0];
                dig[k++] = d[3:0];
            end
            else if (j == s - 1 && md == 2'h1)
            begin
                n = c[0];
                src[j] = sgch(e, n);
            end
            else
            begin
                if (j == s - 1 && md == 2'h0)
                begin
                    c = {$random(seed)} % 6;
                    n = (c == 1) || (c == 3);
                    if (e)
                        src[j][7:4] = 4'ha + c[3:0];
                    else if (n || c != 0)
                        src[j] = opch(n, d[3:0]);
                end
                dig[k++] = d[3:0];
            end
        end
        ps = e ? (n ? 4'hd : 4'hc) : (n ? 4'hb : 4'ha);
        for (j = 0; j < r; j++)
        begin
            if (!o)
                b = (j == 0) ? {dig[0], ps} : {dig[2*j], dig[2*j-1]};
            else if (j != 0)
                b = {z, dig[(md == 2'h0) ? j : j - 1]};
            else if (md != 2'h0)
                b = sgch(e, n);
            else
                b = e ? {ps, dig[0]} : opch(n, dig[0]);
            wq.push_back({8'(r - 1 - j), b});
        end
        // With no result bytes the sign is never sampled, so no fault.
        fq.push_back(o && md == 2'h3 && n && r != 0);
        // Request inputs stay put until the next request.
        @(posedge clk);
        start <= 1'b1;
        op <= o;
        mode <= md;
        ebc <= e;
        sl <= 8'(s);
        rl <= 8'(r);
        @(posedge clk);
        start <= 1'b0;
        for (j = 0; j < 300 && done !== 1'b1; j++) @(posedge clk);
        if (j == 300)
        begin
            errors++;
            end_sim;
        end
        check(16'(wq.size()), 16'h0);
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        for (i = 0; i < 48; i++)
        begin
            m = (i / 4) % 3;
            run(i[0], (m == 2) ? 2'h3 : 2'(m), i[1],
                1 + {$random(seed)} % 8, 1 + {$random(seed)} % 7);
        end
        run(1'b1, 2'h3, 1'b0, 3, 0);
        end_sim;
    end
endmodule
